// ==== rtl/famed_pkg.sv ====
// Package of constants and types shared by the math and error-detect units.
package famed_pkg;
   localparam int                 DATA_W      = 16;
   localparam int                 WIDE_W      = 34;
   localparam logic signed [33:0] VAL_MAX     = 34'sd32767;
   localparam logic signed [33:0] VAL_MIN     = -34'sd32768;
   localparam logic [15:0]        RESULT_RST  = 16'h0000;
   localparam logic               FLAG_RST    = 1'b0;
   localparam logic [1:0]         OP_ADD      = 2'h0;
   localparam logic [1:0]         OP_SUB      = 2'h1;
   localparam logic [1:0]         OP_MUL      = 2'h2;
   localparam logic [1:0]         OP_DIV      = 2'h3;
   localparam logic [1:0]         PRIO_HIGH   = 2'h0;
   localparam logic [1:0]         PRIO_MED    = 2'h1;
   localparam logic [1:0]         PRIO_LOW    = 2'h2;
   localparam logic [1:0]         SEL_ZD      = 2'h0;
   localparam logic [1:0]         SEL_OF      = 2'h1;
   localparam logic [1:0]         SEL_EITHER  = 2'h2;

   // Which error flags the detector watches.
   typedef enum logic [1:0] {
      FAMED_ERR_ZD     = 2'h0,
      FAMED_ERR_OF     = 2'h1,
      FAMED_ERR_EITHER = 2'h2
   } famed_err_sel_t;
endpackage : famed_pkg

// ==== rtl/famed_flags_if.sv ====
// Interface carrying the math unit's error flags to the detector.
`timescale 1ns/1ns
interface famed_flags_if;
   logic zero_division_flag; // Divide by zero in last evaluation.
   logic overflow_flag;      // Overflow in last evaluation.
   logic done;               // High the cycle after each math evaluation; stays high while active.
   modport math (output zero_division_flag, output overflow_flag,
                 output done);
   modport det  (input zero_division_flag, input overflow_flag,
                 input done);
endinterface : famed_flags_if

// ==== rtl/famed_err_detect.sv ====
// Error-detection unit watching the flags of one math unit.
`timescale 1ns/1ns
module famed_err_detect (
   input  wire logic       clk,          // System clock.
   input  wire logic       sys_rst,      // Synchronous reset, active high.
   famed_flags_if.det      flags,        // Flags from the math unit.
   input  wire logic       det_enable,   // Detector enable level.
   input  wire logic       det_clear,    // Explicit output reset.
   input  wire logic       source_math_unit_ref, // Unit referenced.
   input  wire logic       auto_clear,   // 1: output tracks latest evaluation.
   input  wire logic [1:0] err_select,   // Which flag to watch.
   output logic            error_out     // Detector output.
);
   logic error_reg;
   logic error_next;
   logic selected;

   ////////////////////////////////////////////////////////////////////////
   // Flag selection and output state.
   always_comb begin
      unique case (err_select)
         famed_pkg::SEL_ZD: selected = flags.zero_division_flag;
         famed_pkg::SEL_OF: selected = flags.overflow_flag;
         default: selected = flags.zero_division_flag
                           | flags.overflow_flag;
      endcase
      error_next = error_reg;
      // Flags are read in the cycle after evaluation, so the output
      // follows one scan late, as when the math unit runs after this one.
      if (!source_math_unit_ref) begin
         error_next = 1'b0;
      end else if (det_clear) begin
         error_next = 1'b0;
      end else if (det_enable && flags.done) begin
         if (auto_clear) begin
            error_next = selected;
         end else begin
            error_next = error_reg | selected;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         error_reg <= famed_pkg::FLAG_RST;
      end else begin
         error_reg <= error_next;
      end
   end

   assign error_out = error_reg;
endmodule : famed_err_detect

// ==== rtl/famed_math_top.sv ====
// Four-operand math unit with its paired error-detection unit.
`timescale 1ns/1ns
module famed_math_top (
   input  wire logic        clk,             // System clock, 25 MHz.
   input  wire logic        sys_rst,         // Synchronous reset, high.
   input  wire logic        math_enable,     // Math enable level.
   input  wire logic [33:0] operand_one,     // Signed source value.
   input  wire logic [33:0] operand_two,     // Signed source value.
   input  wire logic [33:0] operand_three,   // Signed source value.
   input  wire logic [33:0] operand_four,    // Signed source value.
   input  wire logic [1:0]  operator_one,    // Op between one and two.
   input  wire logic [1:0]  operator_two,    // Op between two and three.
   input  wire logic [1:0]  operator_three,  // Op between three and four.
   input  wire logic [1:0]  priority_one,    // Priority of slot one.
   input  wire logic [1:0]  priority_two,    // Priority of slot two.
   input  wire logic [1:0]  priority_three,  // Priority of slot three.
   input  wire logic        hold_on_disable, // 1: keep result when off.
   input  wire logic        det_enable,      // Detector enable.
   input  wire logic        det_clear,       // Detector reset input.
   input  wire logic        source_math_unit_ref, // Detector has a source.
   input  wire logic        auto_clear,      // Detector auto clear.
   input  wire logic [1:0]  err_select,      // Detector flag select.
   output logic     [15:0]  math_result,     // Signed result.
   output logic             zero_division_flag, // Last run divided by 0.
   output logic             overflow_flag,   // Last run overflowed.
   output logic             error_out        // Detector output.
);
   famed_flags_if flags_bus ();

   logic signed [15:0] result_reg;
   logic signed [15:0] result_next;
   logic               zd_reg;
   logic               zd_next;
   logic               of_reg;
   logic               of_next;
   logic               active_reg;
   logic               active_next;
   logic               en_prev_reg;
   logic               en_prev_next;
   logic               done_reg;
   logic               done_next;

   ////////////////////////////////////////////////////////////////////////
   // Clamp a source value to the signed 16-bit operand range.
   function automatic logic signed [33:0] clamp16(
      input logic signed [33:0] v);
      if (v < famed_pkg::VAL_MIN) begin
         clamp16 = famed_pkg::VAL_MIN;
      end else if (v > famed_pkg::VAL_MAX) begin
         clamp16 = famed_pkg::VAL_MAX;
      end else begin
         clamp16 = v;
      end
   endfunction : clamp16

   // Out-of-range test used on every intermediate value.
   function automatic logic out16(input logic signed [33:0] v);
      out16 = (v < famed_pkg::VAL_MIN) || (v > famed_pkg::VAL_MAX);
   endfunction : out16

   // Rounded division, half away from zero; b is never zero here.
   function automatic logic signed [33:0] rdiv(
      input logic signed [33:0] a,
      input logic signed [33:0] b);
      logic signed [33:0] q;
      logic signed [33:0] r;
      logic signed [33:0] ar;
      logic signed [33:0] ab;
      q  = a / b;
      r  = a % b;
      ar = (r < 0) ? -r : r;
      ab = (b < 0) ? -b : b;
      if (ar + ar >= ab) begin
         q = ((a < 0) != (b < 0)) ? q - 34'sd1 : q + 34'sd1;
      end
      rdiv = q;
   endfunction : rdiv

   // One operation; no saturation here except VAL_MAX on a zero divisor, clamped operands keep products within 34 bits.
   function automatic logic signed [33:0] apply(
      input logic signed [33:0] a,
      input logic [1:0]         op,
      input logic signed [33:0] b);
      logic signed [33:0] p;
      p = '0;
      unique case (op)
         famed_pkg::OP_ADD: p = a + b;
         famed_pkg::OP_SUB: p = a - b;
         famed_pkg::OP_MUL: p = a * b;
         default:           p = (b == 0) ? famed_pkg::VAL_MAX : rdiv(a, b);
      endcase
      apply = p;
   endfunction : apply

   ////////////////////////////////////////////////////////////////////////
   // Priority-ordered evaluation of the three operator slots.
   logic signed [33:0] val [4];
   logic        [1:0]  ops [3];
   logic        [1:0]  pri [3];
   logic signed [33:0] eval_res;
   logic               eval_zd;
   logic               eval_of;

   always_comb begin
      logic signed [33:0] tmp;
      logic               merged [3];
      int                 lft;
      int                 rgt;
      tmp = '0;
      lft = 0;
      rgt = 0;
      merged = '{1'b0, 1'b0, 1'b0};
      eval_zd = 1'b0;
      eval_of = 1'b0;
      val[0] = clamp16(operand_one);
      val[1] = clamp16(operand_two);
      val[2] = clamp16(operand_three);
      val[3] = clamp16(operand_four);
      ops = '{operator_one, operator_two, operator_three};
      pri = '{priority_one, priority_two, priority_three};
      // Each pass folds the slot of the current level into its
      // neighbours; merged slots share the same value chain.
      for (int lvl = 0; lvl < 3; lvl++) begin
         for (int s = 0; s < 3; s++) begin
            if (pri[s] == 2'(lvl)) begin
               lft = s;
               rgt = s + 1;
               // At most two neighbours can have merged; fixed bounds keep
               // the search unrollable.
               for (int j = 0; j < 2; j++) begin
                  if (lft > 0 && merged[lft - 1]) lft--;
                  if (rgt < 3 && merged[rgt]) rgt++;
               end
               if (ops[s] == famed_pkg::OP_DIV && val[rgt] == 0) begin
                  eval_zd = 1'b1;
               end
               tmp = apply(val[lft], ops[s], val[rgt]);
               if (out16(tmp)) begin
                  eval_of = 1'b1;
               end
               tmp = clamp16(tmp);
               for (int k = 0; k < 4; k++) begin
                  if (k >= lft && k <= rgt) val[k] = tmp;
               end
               merged[s] = 1'b1;
            end
         end
      end
      eval_res = tmp;
   end

   ////////////////////////////////////////////////////////////////////////
   // Result and flag registers; evaluates every cycle while active.
   always_comb begin
      result_next  = result_reg;
      zd_next      = zd_reg;
      of_next      = of_reg;
      en_prev_next = math_enable;
      active_next  = active_reg;
      done_next    = 1'b0;
      if (math_enable && !en_prev_reg) begin
         active_next = 1'b1;
      end
      if (!math_enable) begin
         active_next = 1'b0;
         if (!hold_on_disable) begin
            result_next = famed_pkg::RESULT_RST;
         end
      end else if (active_reg || !en_prev_reg) begin
         zd_next   = eval_zd;
         of_next   = eval_of;
         done_next = 1'b1;
         if (eval_zd) begin
            result_next = famed_pkg::VAL_MAX[15:0];
         end else begin
            result_next = eval_res[15:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result_reg  <= famed_pkg::RESULT_RST;
         zd_reg      <= famed_pkg::FLAG_RST;
         of_reg      <= famed_pkg::FLAG_RST;
         active_reg  <= 1'b0;
         en_prev_reg <= 1'b0;
         done_reg    <= 1'b0;
      end else begin
         result_reg  <= result_next;
         zd_reg      <= zd_next;
         of_reg      <= of_next;
         active_reg  <= active_next;
         en_prev_reg <= en_prev_next;
         done_reg    <= done_next;
      end
   end

   assign math_result           = result_reg;
   assign zero_division_flag    = zd_reg;
   assign overflow_flag         = of_reg;
   assign flags_bus.zero_division_flag = zd_reg;
   assign flags_bus.overflow_flag      = of_reg;
   assign flags_bus.done               = done_reg;

   ////////////////////////////////////////////////////////////////////////
   // Paired error detector.
   famed_err_detect u_det (
      .clk                  (clk),
      .sys_rst              (sys_rst),
      .flags                (flags_bus),
      .det_enable           (det_enable),
      .det_clear            (det_clear),
      .source_math_unit_ref (source_math_unit_ref),
      .auto_clear           (auto_clear),
      .err_select           (err_select),
      .error_out            (error_out)
   );
endmodule : famed_math_top

// ==== verif/famed_asserts.sv ====
// Concurrent checks on the math unit and its error detector.
`timescale 1ns/1ns
module famed_asserts (
   input wire logic        clk,                  // Clock.
   input wire logic        sys_rst,              // Reset.
   input wire logic        math_enable,          // Math enable.
   input wire logic        hold_on_disable,      // Hold setting.
   input wire logic        det_enable,           // Detector enable.
   input wire logic        det_clear,            // Detector clear.
   input wire logic        source_math_unit_ref, // Source present.
   input wire logic        auto_clear,           // Auto clear.
   input wire logic [1:0]  err_select,           // Flag select.
   input wire logic [15:0] math_result,          // Result.
   input wire logic        zero_division_flag,   // Zero division.
   input wire logic        overflow_flag,        // Overflow.
   input wire logic        error_out             // Detector output.
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Detector follows the latest flags only when nothing else interferes.
   wire logic auto_ok;
   assign auto_ok = det_enable && auto_clear && source_math_unit_ref
                    && !det_clear;
   ////////////////////////////////////////////////////////////////////////
   a_off_zero: assert property (
      !math_enable && !hold_on_disable |=> math_result == 16'h0000)
      else $error("Result not cleared while disabled.");
   a_off_hold: assert property (
      !math_enable && hold_on_disable |=> $stable(math_result))
      else $error("Result not held while disabled.");
   a_zd_saturate: assert property (
      $rose(zero_division_flag) |-> math_result == 16'h7fff)
      else $error("Zero division result not saturated.");
   a_no_source: assert property (
      !source_math_unit_ref |=> !error_out)
      else $error("Detector high without a source.");
   a_clear_out: assert property (
      det_clear && det_enable |=> !error_out)
      else $error("Detector not cleared.");
   a_sticky_hold: assert property (
      error_out && !auto_clear && !det_clear && source_math_unit_ref
      |=> error_out)
      else $error("Sticky detector output dropped.");
   a_auto_zd: assert property (
      auto_ok && err_select == 2'h0 |=> error_out == $past(zero_division_flag))
      else $error("Detector does not follow zero division flag.");
   a_auto_of: assert property (
      auto_ok && err_select == 2'h1 |=> error_out == $past(overflow_flag))
      else $error("Detector does not follow overflow flag.");
   a_auto_either: assert property (
      auto_ok && err_select == 2'h2
      |=> error_out == ($past(zero_division_flag) | $past(overflow_flag)))
      else $error("Detector does not follow either flag.");
endmodule : famed_asserts

bind famed_math_top famed_asserts i_chk (.clk, .sys_rst, .math_enable,
   .hold_on_disable, .det_enable, .det_clear, .source_math_unit_ref,
   .auto_clear, .err_select, .math_result, .zero_division_flag,
   .overflow_flag, .error_out);

// ==== verif/famed_src_model.sv ====
// Upstream block model that supplies the four operand values.
`timescale 1ns/1ns
module famed_src_model (
   input  wire logic         clk,      // Clock.
   input  wire logic         sys_rst,  // Synchronous reset.
   input  wire logic         load,     // Take new values.
   input  wire logic [135:0] vals_in,  // Four values, operand one lowest.
   output logic      [135:0] vals_out  // Values seen by the math unit.
);
   // Registered like a real block, so values change one cycle after load.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         vals_out <= 136'h0;
      end else if (load) begin
         vals_out <= vals_in;
      end
   end
endmodule : famed_src_model

// ==== verif/tb.sv ====
// Self-checking testbench for the math unit with error detection.
`timescale 1ns/1ns
module tb;
   logic         clk, sys_rst, math_enable, hold_on_disable, load;
   logic         det_enable, det_clear, source_math_unit_ref, auto_clear;
   logic         zd, of, error_out;
   logic [1:0]   err_select;
   logic [5:0]   ops, prs;
   logic [15:0]  math_result;
   logic [135:0] vals_in, vals;
   int           error_cnt, compares;

   famed_src_model i_src (.clk(clk), .sys_rst(sys_rst), .load(load),
      .vals_in(vals_in), .vals_out(vals));
   famed_math_top i_dut (.clk(clk), .sys_rst(sys_rst),
      .math_enable(math_enable), .operand_one(vals[33:0]),
      .operand_two(vals[67:34]), .operand_three(vals[101:68]),
      .operand_four(vals[135:102]), .operator_one(ops[1:0]),
      .operator_two(ops[3:2]), .operator_three(ops[5:4]),
      .priority_one(prs[1:0]), .priority_two(prs[3:2]),
      .priority_three(prs[5:4]), .hold_on_disable(hold_on_disable),
      .det_enable(det_enable), .det_clear(det_clear),
      .source_math_unit_ref(source_math_unit_ref),
      .auto_clear(auto_clear), .err_select(err_select),
      .math_result(math_result), .zero_division_flag(zd),
      .overflow_flag(of), .error_out(error_out));

   ////////////////////////////////////////////////////////////////////////
   // Free-running clock, 40 ns period.
   always #20 clk = ~clk;

   // Packs four signed values, sign-extended to the operand width.
   function automatic logic [135:0] pk(input int a, b, c, d);
      return {34'(d), 34'(c), 34'(b), 34'(a)};
   endfunction : pk

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One evaluation: load the source, let it settle, then check outputs.
   task automatic eval(input logic [135:0] v, input logic [5:0] o, p,
                       input logic [15:0] exp, input logic [1:0] fl,
                       input logic e);
      @(posedge clk);
      vals_in <= v;
      load <= 1'b1;
      math_enable <= 1'b1;
      // Operators follow the source's one-cycle lag, so no cycle mixes
      // new operators with old operands and raises a false flag.
      @(posedge clk);
      load <= 1'b0;
      ops <= o;
      prs <= p;
      @(posedge clk);
      @(negedge clk);
      check(math_result, exp);
      check({14'h0, zd, of}, {14'h0, fl});
      @(negedge clk);
      check({15'h0, error_out}, {15'h0, e});
   endtask : eval

   task automatic tally_and_finish;
      $display("Mismatches %0d, comparisons %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////
   // Watchdog after 5000 cycles: the sequence needs well under that.
   initial begin
      #200000;
      error_cnt++;
      tally_and_finish();
   end

   // Main sequence; unused slots are filled with adds of zero.
   initial begin
      {clk, math_enable, hold_on_disable, load, det_clear} = 5'h00;
      {sys_rst, det_enable, source_math_unit_ref, auto_clear} = 4'hf;
      {err_select, ops, prs, vals_in, error_cnt, compares} = '0;
      err_select = 2'h2;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      eval(pk(12, 6, 3, 1), 6'h1c, 6'h21, 16'h000d, 2'b00, 1'b0);
      eval(pk(2, 3, 1, 4), 6'h08, 6'h06, 16'h0011, 2'b00, 1'b0);
      eval(pk(100, 25, 2, 1), 6'h0d, 6'h18, 16'h0019, 2'b00, 1'b0);
      eval(pk(7, 2, 0, 0), 6'h03, 6'h24, 16'h0004, 2'b00, 1'b0);
      eval(pk(-7, 2, 0, 0), 6'h03, 6'h24, 16'hfffc, 2'b00, 1'b0);
      eval(pk(40000, 0, 0, 0), 6'h00, 6'h24, 16'h7fff, 2'b00,
           1'b0);
      eval(pk(-40000, 0, 0, 0), 6'h00, 6'h24, 16'h8000, 2'b00,
           1'b0);
      eval(pk(-300, 300, 0, 0), 6'h02, 6'h24, 16'h8000, 2'b01,
           1'b1);
      // Each flag select, against a zero division and an overflow.
      for (int s = 0; s < 3; s++) begin
         @(posedge clk);
         err_select <= 2'(s);
         eval(pk(5, 0, 0, 0), 6'h03, 6'h24, 16'h7fff, 2'b10,
              s != 1);
         eval(pk(300, 300, 0, 0), 6'h02, 6'h24, 16'h7fff, 2'b01,
              s != 0);
      end
      // Disable with hold, then with clear; re-enable must evaluate again.
      @(posedge clk);
      math_enable <= 1'b0;
      hold_on_disable <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(math_result, 16'h7fff);
      @(posedge clk);
      hold_on_disable <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(math_result, 16'h0000);
      // Sticky output on zero division only: the level left by the
      // overflow runs is cleared first, so only a new error can set it.
      @(posedge clk);
      auto_clear <= 1'b0;
      err_select <= 2'h0;
      det_clear <= 1'b1;
      @(posedge clk);
      det_clear <= 1'b0;
      @(negedge clk);
      check({15'h0, error_out}, 16'h0000);
      eval(pk(5, 0, 0, 0), 6'h03, 6'h24, 16'h7fff, 2'b10, 1'b1);
      eval(pk(12, 6, 3, 1), 6'h1c, 6'h21, 16'h000d, 2'b00, 1'b1);
      @(posedge clk);
      det_clear <= 1'b1;
      @(posedge clk);
      det_clear <= 1'b0;
      @(negedge clk);
      check({15'h0, error_out}, 16'h0000);
      // With no source referenced the output never rises.
      @(posedge clk);
      auto_clear <= 1'b1;
      source_math_unit_ref <= 1'b0;
      eval(pk(5, 0, 0, 0), 6'h03, 6'h24, 16'h7fff, 2'b10, 1'b0);
      tally_and_finish();
   end
endmodule : tb
